// >>> logic/mhb_core.sv
// Header controller: start, selector, arbitration, addresses, acknowledge.
// Behaviour
// R1 - Broadcast-type frame beats one-to-one frame
// R2 - Lowest master address wins among equals
// R3 - Three speed modes limit payload size
// R4 - Speed mode fixed before any communication
// R5 - Twelve-bit address: group and unit
// R6 - Start bit low, then selector bit
// R7 - Join foreign start bit, align selector
// R8 - Non-initiators detect start, enter receive
// R9 - Selector zero many, one single
// R10 - Multi-unit frames carry no acknowledge
// R11 - Selector comes from control bit seven
// R12 - Compare each address bit, lose on mismatch
// R13 - Low dominates, one survivor after twelve
// R14 - Winner sends parity then slave address
// R15 - Own address from own-address registers
// R16 - Check acknowledge unless multi-unit frame
// R17 - Acknowledge only on match, even parities
// R18 - No acknowledge ends frame, back to standby
// R19 - FFF broadcast, else group from top
// R20 - Accept group match or any broadcast
// R21 - Destination from target-address registers
// R22 - Even parity, most significant bit first
// R23 - Report lost arbitration and missing acknowledge
`timescale 1ns/100ps
`default_nettype none
module mhb_core
  import mhb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] speed_mode,
  input wire logic [7:0] master_frame_control_reg,
  input wire logic [7:0] own_address_reg_a,
  input wire logic [3:0] own_address_reg_b,
  input wire logic [7:0] target_address_reg_a,
  input wire logic [3:0] target_address_reg_b,
  input wire logic tx_req,
  output logic busy,
  output logic arb_lost,
  output logic nack,
  output logic header_done,
  output logic is_master,
  output logic rx_accept,
  output logic rx_multi,
  output logic [11:0] rx_master_addr,
  output logic [7:0] payload_limit,
  output logic bus_out,
  output logic bus_oe_n,
  input wire logic bus_in
);
  import mhb_pkg::*;

  typedef struct packed {
    logic [1:0] sync;
    logic prev;
    mhb_phase_t ph;
    logic [CNT_W-1:0] cnt;
    logic [3:0] idx;
    logic master;
    logic multi;
    logic [11:0] tx_sh;
    logic [11:0] rx_sh;
    logic [11:0] maddr;
    logic par;
    logic par_ok;
    logic pend;
    logic [1:0] mode;
    logic busy;
    logic arb_lost;
    logic nack;
    logic done;
    logic accept;
    logic drv_low;
    logic [7:0] limit;
  } mhb_state_t;

  mhb_state_t r, nx;
  logic [CNT_W-1:0] bit_cyc;
  logic [11:0] own_addr;
  logic [11:0] dst_addr;
  logic line_s;
  logic fall;
  logic mid;
  logic last;
  logic match;

  // R5 own address split
  assign own_addr = {own_address_reg_b, own_address_reg_a};
  assign dst_addr = {target_address_reg_b, target_address_reg_a};
  assign line_s = r.sync[1];
  assign fall = r.prev & ~line_s;

  always_comb begin
    unique case (r.mode)
      MODE1: bit_cyc = CNT_W'(BIT_CYC_MODE1);
      MODE2: bit_cyc = CNT_W'(BIT_CYC_MODE2);
      default: bit_cyc = CNT_W'(BIT_CYC_MODE0);
    endcase
  end

  assign mid = (r.cnt == (bit_cyc >> 1));
  assign last = (r.cnt == bit_cyc - CNT_W'(1));

  // R19 broadcast or group decode
  // R20 accept group match or broadcast
  assign match = r.multi
    ? ((r.rx_sh == BCAST_ADDR) ||
       (r.rx_sh[GROUP_MSB:GROUP_LSB] == own_addr[GROUP_MSB:GROUP_LSB]))
    : (r.rx_sh == own_addr);

  always_comb begin
    nx = r;
    nx.sync = {r.sync[0], bus_in};
    nx.prev = line_s;
    nx.arb_lost = 1'b0;
    nx.nack = 1'b0;
    nx.done = 1'b0;
    nx.cnt = r.cnt + CNT_W'(1);
    unique case (r.ph)
      MHB_IDLE: begin
        nx.drv_low = 1'b0;
        nx.cnt = '0;
        // R4 mode latched only between frames
        nx.mode = speed_mode;
        // R3 payload limit per mode
        unique case (speed_mode)
          MODE1: nx.limit = PAYLOAD_MODE1;
          MODE2: nx.limit = PAYLOAD_MODE2;
          default: nx.limit = PAYLOAD_MODE0;
        endcase
        if (tx_req) nx.pend = 1'b1;
        nx.accept = 1'b0;
        // R7 join a foreign start bit
        // R8 detect start and receive
        if (fall) begin
          nx.ph = MHB_START;
          nx.master = r.pend | tx_req;
          nx.busy = 1'b1;
          nx.cnt = CNT_W'(2);
        end else if (r.pend & line_s) begin
          // R6 drive start bit low
          nx.ph = MHB_START;
          nx.master = 1'b1;
          nx.busy = 1'b1;
          nx.drv_low = 1'b1;
        end
      end
      MHB_START: begin
        if (r.cnt == CNT_W'(START_CYC - 1)) begin
          nx.cnt = '0;
          nx.ph = MHB_SEL;
          nx.pend = 1'b0;
          // R11 selector from control bit seven
          nx.drv_low = r.master & ~master_frame_control_reg[SEL_BIT];
          nx.tx_sh = own_addr;
        end
      end
      default: begin
        if (mid) begin
          // Only address bits enter the shifter, so a parity bit never
          // spoils the slave address compared at the end of the field.
          if (r.ph == MHB_MADDR || r.ph == MHB_SADDR) begin
            nx.rx_sh = {r.rx_sh[10:0], line_s};
          end
          // R2 lowest master address survives
          // R12 compare address bit with line
          // R13 low dominates, loser drops out
          // R1 selector mismatch loses too
          if (r.master && (r.ph == MHB_SEL || r.ph == MHB_MADDR) &&
              (line_s == r.drv_low)) begin
            nx.master = 1'b0;
            nx.drv_low = 1'b0;
            nx.arb_lost = 1'b1;
          end
          // R9 selector low means multi
          if (r.ph == MHB_SEL) nx.multi = ~line_s;
          else nx.par = r.par ^ line_s;
        end
        if (r.ph == MHB_ACK && mid) begin
          // R16 check acknowledge
          // R10 multi-unit frames skip it
          // R18 no acknowledge ends frame
          if (r.master && !r.multi && line_s) nx.nack = 1'b1;
          else nx.done = r.master | r.accept;
        end
        if (last) begin
          nx.cnt = '0;
          nx.idx = r.idx + 4'h1;
          nx.drv_low = 1'b0;
          unique case (r.ph)
            MHB_SEL: begin
              nx.ph = MHB_MADDR;
              nx.idx = '0;
              nx.par = 1'b0;
            end
            MHB_MADDR: if (r.idx == 4'(ADDR_W - 1)) begin
              nx.ph = MHB_MPAR;
              nx.maddr = r.rx_sh;
            end
            MHB_MPAR: begin
              nx.ph = MHB_SADDR;
              nx.idx = '0;
              nx.par_ok = ~r.par;
              nx.par = 1'b0;
              nx.tx_sh = dst_addr;
            end
            MHB_SADDR: if (r.idx == 4'(ADDR_W - 1)) nx.ph = MHB_SPAR;
            MHB_SPAR: begin
              nx.ph = MHB_ACK;
              // R17 acknowledge on match and even parity
              nx.accept = ~r.master & match & r.par_ok & ~r.par;
              nx.drv_low = ~r.master & ~r.multi & match & r.par_ok & ~r.par;
            end
            default: begin
              nx.ph = MHB_IDLE;
              nx.busy = 1'b0;
            end
          endcase
          // R22 even parity, MSB first
          // R14 parity then slave address
          // R15 own address shifted out
          // R21 target address shifted out
          if (r.master) begin
            unique case (nx.ph)
              MHB_MADDR, MHB_SADDR: begin
                // The target address is loaded in this same cycle.
                nx.drv_low = ~nx.tx_sh[11 - nx.idx];
              end
              MHB_MPAR: nx.drv_low = ~(^own_addr);
              MHB_SPAR: nx.drv_low = ~(^dst_addr);
              default: ;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.sync <= 2'h3;
      r.prev <= 1'b1;
      r.limit <= PAYLOAD_MODE0;
    end else begin
      r <= nx;
    end
  end

  assign busy = r.busy;
  // R23 report arbitration loss and nack
  assign arb_lost = r.arb_lost;
  assign nack = r.nack;
  assign header_done = r.done;
  assign is_master = r.master;
  assign rx_accept = r.accept;
  assign rx_multi = r.multi;
  assign rx_master_addr = r.maddr;
  assign payload_limit = r.limit;
  assign bus_out = 1'b0;
  assign bus_oe_n = ~r.drv_low;
endmodule // mhb_core
`default_nettype wire

// >>> common/mhb_pkg.sv
// Package of constants and types shared by both ends of the header link.
package mhb_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  // Bit times in ns per speed mode (plain defaults).
  localparam int BIT_NS_MODE0 = 40000;
  localparam int BIT_NS_MODE1 = 10000;
  localparam int BIT_NS_MODE2 = 6000;
  localparam int START_NS = 20000;
  localparam int BIT_CYC_MODE0 = BIT_NS_MODE0 * CLK_MHZ / 1000;
  localparam int BIT_CYC_MODE1 = BIT_NS_MODE1 * CLK_MHZ / 1000;
  localparam int BIT_CYC_MODE2 = BIT_NS_MODE2 * CLK_MHZ / 1000;
  localparam int START_CYC = START_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 16;

  // ****************************************
  // Fields
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int GROUP_MSB = 11;
  localparam int GROUP_LSB = 8;
  localparam int SEL_BIT = 7;
  localparam logic [11:0] BCAST_ADDR = 12'hFFF;
  localparam logic [7:0] PAYLOAD_MODE0 = 8'h10;
  localparam logic [7:0] PAYLOAD_MODE1 = 8'h20;
  localparam logic [7:0] PAYLOAD_MODE2 = 8'h80;
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;

  typedef enum logic [3:0] {
    MHB_IDLE, MHB_START, MHB_SEL, MHB_MADDR, MHB_MPAR,
    MHB_SADDR, MHB_SPAR, MHB_ACK, MHB_WAIT_END
  } mhb_phase_t;

endpackage

// >>> common/mhb_if.sv
// Interface carrying the single wired-AND bus line between two ends.
`timescale 1ns/100ps
`default_nettype none
interface mhb_if;
  logic dev_out;
  logic dev_oe_n;
  logic peer_out;
  logic peer_oe_n;
  logic line;
  // Wired-AND: any enabled driver with a low value pulls the line low; a high value does not force it high.
  assign line = (dev_oe_n | dev_out) & (peer_oe_n | peer_out);
  modport dev (output dev_out, output dev_oe_n, input line);
  modport peer (output peer_out, output peer_oe_n, input line);
endinterface
`default_nettype wire

// >>> logic/mhb_dev_end.sv
// Device end: the header controller tied to the device modport.
`timescale 1ns/100ps
`default_nettype none
module mhb_dev_end
  import mhb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  mhb_if.dev link,
  input wire logic [1:0] speed_mode,
  input wire logic [7:0] master_frame_control_reg,
  input wire logic [7:0] own_address_reg_a,
  input wire logic [3:0] own_address_reg_b,
  input wire logic [7:0] target_address_reg_a,
  input wire logic [3:0] target_address_reg_b,
  input wire logic tx_req,
  output logic busy,
  output logic arb_lost,
  output logic nack,
  output logic header_done,
  output logic is_master,
  output logic rx_accept,
  output logic rx_multi,
  output logic [11:0] rx_master_addr,
  output logic [7:0] payload_limit
);
  import mhb_pkg::*;
  mhb_core u_core (
    .clk(clk), .nrst(nrst), .speed_mode(speed_mode),
    .master_frame_control_reg(master_frame_control_reg),
    .own_address_reg_a(own_address_reg_a),
    .own_address_reg_b(own_address_reg_b),
    .target_address_reg_a(target_address_reg_a),
    .target_address_reg_b(target_address_reg_b),
    .tx_req(tx_req), .busy(busy), .arb_lost(arb_lost), .nack(nack),
    .header_done(header_done), .is_master(is_master),
    .rx_accept(rx_accept), .rx_multi(rx_multi),
    .rx_master_addr(rx_master_addr), .payload_limit(payload_limit),
    .bus_out(link.dev_out), .bus_oe_n(link.dev_oe_n), .bus_in(link.line)
  );
endmodule // mhb_dev_end
`default_nettype wire

// >>> logic/mhb_peer_end.sv
// Peer end: the same controller facing the bus from the far side.
`timescale 1ns/100ps
`default_nettype none
module mhb_peer_end
  import mhb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  mhb_if.peer link,
  input wire logic [1:0] speed_mode,
  input wire logic [7:0] master_frame_control_reg,
  input wire logic [7:0] own_address_reg_a,
  input wire logic [3:0] own_address_reg_b,
  input wire logic [7:0] target_address_reg_a,
  input wire logic [3:0] target_address_reg_b,
  input wire logic tx_req,
  output logic busy,
  output logic arb_lost,
  output logic nack,
  output logic header_done,
  output logic is_master,
  output logic rx_accept,
  output logic rx_multi,
  output logic [11:0] rx_master_addr,
  output logic [7:0] payload_limit
);
  import mhb_pkg::*;
  // The far party keeps the same rules, so it reuses the controller.
  mhb_core u_core (
    .clk(clk), .nrst(nrst), .speed_mode(speed_mode),
    .master_frame_control_reg(master_frame_control_reg),
    .own_address_reg_a(own_address_reg_a),
    .own_address_reg_b(own_address_reg_b),
    .target_address_reg_a(target_address_reg_a),
    .target_address_reg_b(target_address_reg_b),
    .tx_req(tx_req), .busy(busy), .arb_lost(arb_lost), .nack(nack),
    .header_done(header_done), .is_master(is_master),
    .rx_accept(rx_accept), .rx_multi(rx_multi),
    .rx_master_addr(rx_master_addr), .payload_limit(payload_limit),
    .bus_out(link.peer_out), .bus_oe_n(link.peer_oe_n), .bus_in(link.line)
  );
endmodule // mhb_peer_end
`default_nettype wire

// >>> testbench/mhb_monitor.sv
// Checker watching the shared bus line and the drivers of both ends.
`timescale 1ns/100ps
`default_nettype none
module mhb_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic peer_out,
  input wire logic peer_oe_n,
  input wire logic line
);
  import mhb_pkg::*;
  // ****************************************
  // Run counters
  // ****************************************
  // Bounds are loose so the one-cycle join lag never trips them.
  localparam logic [15:0] MIN_BIT = 16'h03E8;
  localparam logic [15:0] MIN_START = 16'h0F96;
  localparam logic [15:0] IDLE_RUN = 16'h4E20;
  logic [15:0] dev_gap;
  logic [15:0] peer_gap;
  logic [15:0] low_run;
  logic [15:0] high_run;
  logic from_idle;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dev_gap <= 16'hFFFF;
      peer_gap <= 16'hFFFF;
      low_run <= 16'h0000;
      high_run <= 16'hFFFF;
      from_idle <= 1'b0;
    end else begin
      dev_gap <= $changed(dev_oe_n) ? 16'h0000 : dev_gap + {15'h0000, ~&dev_gap};
      peer_gap <= $changed(peer_oe_n) ? 16'h0000 : peer_gap + {15'h0000, ~&peer_gap};
      low_run <= line ? 16'h0000 : low_run + {15'h0000, ~&low_run};
      high_run <= !line ? 16'h0000 : high_run + {15'h0000, ~&high_run};
      if ($fell(line)) begin
        from_idle <= (high_run >= IDLE_RUN);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_dev_drives_low: assert property (dev_out == 1'b0)
    else $error("device end drives a high level");
  a_peer_drives_low: assert property (peer_out == 1'b0)
    else $error("peer end drives a high level");
  a_dev_bit_hold: assert property ($changed(dev_oe_n) |-> dev_gap >= MIN_BIT)
    else $error("device end changed its drive inside a bit");
  a_peer_bit_hold: assert property ($changed(peer_oe_n) |-> peer_gap >= MIN_BIT)
    else $error("peer end changed its drive inside a bit");
  a_low_run_min: assert property ($rose(line) |-> low_run >= MIN_BIT)
    else $error("low level shorter than one bit");
  a_high_run_min: assert property ($fell(line) |-> high_run >= MIN_BIT)
    else $error("high level shorter than one bit");
  a_reset_idle: assert property ($rose(nrst) |-> dev_oe_n && peer_oe_n)
    else $error("a driver is enabled straight after reset");
  a_start_length: assert property ($rose(line) && from_idle |-> low_run >= MIN_START)
    else $error("start bit too short");
endmodule // mhb_monitor
`default_nettype wire

// >>> testbench/test_mhb.sv
// Testbench joining a device end and a peer end on one shared bus line.
`timescale 1ns/100ps
`default_nettype none
module test_mhb;
  import mhb_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic clk;
  logic nrst;
  logic [1:0] mode;
  logic [7:0] d_ctl, p_ctl, d_pl, p_pl;
  logic [11:0] d_own, p_own, d_tgt, p_tgt, d_rma, p_rma;
  logic d_req, p_req, d_busy, p_busy, d_lost, p_lost, d_nack, p_nack;
  logic d_done, p_done, d_acc, p_acc, d_multi, p_multi;
  logic d_mst, p_mst;
  logic [9:0] seen;
  int mismatches = 0;
  int comparisons = 0;
  mhb_if bus ();
  mhb_dev_end u_mhb_dev_end (.clk(clk), .nrst(nrst), .link(bus),
    .speed_mode(mode), .master_frame_control_reg(d_ctl),
    .own_address_reg_a(d_own[7:0]), .own_address_reg_b(d_own[11:8]),
    .target_address_reg_a(d_tgt[7:0]), .target_address_reg_b(d_tgt[11:8]),
    .tx_req(d_req), .busy(d_busy), .arb_lost(d_lost), .nack(d_nack),
    .header_done(d_done), .is_master(d_mst), .rx_accept(d_acc),
    .rx_multi(d_multi), .rx_master_addr(d_rma), .payload_limit(d_pl));
  mhb_peer_end u_mhb_peer_end (.clk(clk), .nrst(nrst), .link(bus),
    .speed_mode(mode), .master_frame_control_reg(p_ctl),
    .own_address_reg_a(p_own[7:0]), .own_address_reg_b(p_own[11:8]),
    .target_address_reg_a(p_tgt[7:0]), .target_address_reg_b(p_tgt[11:8]),
    .tx_req(p_req), .busy(p_busy), .arb_lost(p_lost), .nack(p_nack),
    .header_done(p_done), .is_master(p_mst), .rx_accept(p_acc),
    .rx_multi(p_multi), .rx_master_addr(p_rma), .payload_limit(p_pl));
  mhb_monitor u_mhb_monitor (.clk(clk), .nrst(nrst), .dev_out(bus.dev_out),
    .dev_oe_n(bus.dev_oe_n), .peer_out(bus.peer_out),
    .peer_oe_n(bus.peer_oe_n), .line(bus.line));
  always #2.5 clk = ~clk;
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Both ends request together; events are gathered until both ends are idle or both have reported done.
  task automatic run_frame(input logic [7:0] dc, input logic [7:0] pc,
      input logic [11:0] da, input logic [11:0] pa,
      input logic [11:0] dt, input logic [11:0] pt);
    int n;
    int quiet;
    // A request is only taken in idle, and a bit time of high line
    // keeps every level on the bus at least one bit long.
    while ((d_busy | p_busy) !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    repeat (BIT_CYC_MODE2) @(posedge clk);
    #1;
    d_ctl = dc;
    p_ctl = pc;
    d_own = da;
    p_own = pa;
    d_tgt = dt;
    p_tgt = pt;
    d_req = 1'b1;
    p_req = 1'b1;
    seen = '0;
    n = 0;
    quiet = 0;
    do begin
      @(posedge clk);
      #1;
      d_req = 1'b0;
      p_req = 1'b0;
      seen = seen | {d_lost, p_lost, d_nack, p_nack, d_done, p_done,
                     d_acc, p_acc, p_multi, d_multi};
      quiet = ((d_busy | p_busy) === 1'b0 || (seen[5] & seen[4])) ? quiet + 1 : 0;
      n++;
    end while (quiet < 8 && n < 45000);
    // A frame that never settles counts against the run.
    check({11'h000, quiet >= 8}, 12'h001);
  endtask
  // Each speed mode sets its payload limit while both ends stand idle.
  task automatic mode_limits;
    mode = MODE1;
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, d_pl}, {4'h0, PAYLOAD_MODE1});
    check({4'h0, p_pl}, {4'h0, PAYLOAD_MODE1});
    mode = MODE0;
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, d_pl}, {4'h0, PAYLOAD_MODE0});
    check({4'h0, p_pl}, {4'h0, PAYLOAD_MODE0});
    mode = MODE2;
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, p_pl}, {4'h0, PAYLOAD_MODE2});
    check({10'h000, d_busy, p_busy}, 12'h000);
  endtask
  // Same frame type: the lower master address takes the bus.
  task automatic arb_by_address;
    run_frame(8'h80, 8'h80, 12'h100, 12'h0FF, 12'h0FF, 12'h100);
    check({2'h0, seen}, 12'h238);
    check(d_rma, 12'h0FF);
    check({10'h000, d_mst, p_mst}, 12'h001);
    check({4'h0, d_pl}, {4'h0, PAYLOAD_MODE2});
  endtask
  // Broadcast beats one-to-one even from a higher address.
  task automatic arb_by_type;
    run_frame(8'h00, 8'h80, 12'h200, 12'h001, BCAST_ADDR, 12'h200);
    check({2'h0, seen}, 12'h137);
    check(p_rma, 12'h200);
    check(d_rma, 12'h200);
    check({10'h000, d_mst, p_mst}, 12'h002);
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    mode = MODE2;
    d_ctl = 8'h00;
    p_ctl = 8'h00;
    d_own = 12'h000;
    p_own = 12'h000;
    d_tgt = 12'h000;
    p_tgt = 12'h000;
    d_req = 1'b0;
    p_req = 1'b0;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({11'h000, bus.line}, 12'h001);
    mode_limits;
    arb_by_address;
    arb_by_type;
    finish_test;
  end
  initial begin
    #500000;
    mismatches++;
    finish_test;
  end
endmodule // test_mhb
`default_nettype wire
